// ==== src/pusd_pkg.sv ====
package pusd_pkg;

  // ----------------------------------------------------------------------
  // switch bank layout
  // ----------------------------------------------------------------------
  localparam int SW_W = 7;
  localparam int ID_LSB = 0;
  localparam int ID_W = 4;
  localparam int BAUD_LSB = 4;
  localparam int BAUD_W = 3;
  localparam logic [3:0] ID_SERVICE_CODE = 4'hf;
  localparam logic [3:0] ID_OFFSET = 4'h1;
  localparam int OUT_N = 10;
  localparam logic [9:0] ROUTE_ALL = 10'h3ff;
  localparam logic [3:0] REPLY_DEFAULT = 4'h1;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int DEBOUNCE_MS = 20;
  localparam int DEBOUNCE_CYC = DEBOUNCE_MS * 1000 * CLK_MHZ;
  localparam int BLINK_HALF_MS = 250;
  localparam int BLINK_HALF_CYC = BLINK_HALF_MS * 1000 * CLK_MHZ;
  localparam int BLINK_COUNT = 4;
  localparam int SETTLE_CYC = 16;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    PUSD_BAUD_1200 = 3'h0,
    PUSD_BAUD_2400 = 3'h1,
    PUSD_BAUD_4800 = 3'h2,
    PUSD_BAUD_9600 = 3'h3,
    PUSD_BAUD_19200 = 3'h4
  } pusd_baud_t;

  typedef struct packed {
    logic valid;
    logic [3:0] unit_id;
    logic service_mode;
    pusd_baud_t baud;
    logic factory_reset;
  } pusd_cfg_t;

  typedef struct packed {
    logic [9:0] route_mask;
    logic [3:0] reply_output;
  } pusd_route_t;

endpackage

// ==== src/pusd_debounce.sv ====
`timescale 1ns/1ps
module pusd_debounce #(
  parameter int WIDTH = 1,
  parameter int STABLE_CYC = 4000000
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // raw pins and filtered levels
  input wire logic [WIDTH-1:0] raw,
  output logic [WIDTH-1:0] clean
);
  localparam int CW = $clog2(STABLE_CYC + 1);
  initial begin
    if (WIDTH < 1 || STABLE_CYC < 1) $error("pusd_debounce: bad parameters");
  end

  genvar g;
  for (g = 0; g < WIDTH; g++) begin : g_bit
    logic s1, s2, s3;
    logic [CW-1:0] cnt;
    // s1 feeds only s2; stable when s2 and s3 agree
    wire agree = (s2 == s3);
    wire differs = agree && (s3 != clean[g]);
    always_ff @(posedge core_clk) begin
      s1 <= raw[g];
      s2 <= s1;
      s3 <= s2;
    end
    always_ff @(posedge core_clk) begin
      if (rst) begin
        cnt <= '0;
        clean[g] <= 1'b0;
      end else if (!differs) begin
        cnt <= '0;
      end else if (cnt == CW'(STABLE_CYC - 1)) begin
        cnt <= '0;
        clean[g] <= s3;
      end else begin
        cnt <= cnt + 1'b1;
      end
    end
  end
endmodule // pusd_debounce

// ==== src/pusd_setup.sv ====
`timescale 1ns/1ps
// How it works
// R1 - switches are latched once after power-up settling and never looked at again.
// R2 - the unit number is the binary code on switches one to four plus one.
// R3 - the latched unit number is presented as the remote-control identity.
// R4 - the all-on identity code is reserved and never used as an operating identity.
// R5 - the all-on code at power-up enables network parameter setup from a host tool.
// R6 - the all-on code also enables flash upgrade and holds until the next power cycle.
// R7 - switches five to seven select 1200, 2400, 4800, 9600 or 19200 baud.
// R8 - all units sharing a serial chain must be given the same baud code by the installer.
// R9 - a capture press reads the display identity, then the indicator blinks slowly a few times.
// R10 - factory reset held at power-up loads default display identity and default parameters.
// R11 - after factory reset control data goes to all ten outputs and replies come from output one.
// R12 - undefined baud codes give 9600 and all pins are synchronised and debounced.
module pusd_setup
  import pusd_pkg::*;
#(
  parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC,
  parameter int BLINK_HALF_CYCLES = BLINK_HALF_CYC,
  parameter int BLINKS = BLINK_COUNT
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // setup switches and buttons (high = on / pressed)
  input wire logic [pusd_pkg::SW_W-1:0] setup_switch,
  input wire logic display_id_capture_button,
  input wire logic factory_reset_button,
  // display identity capture engine
  output logic display_id_read_start,
  input wire logic display_id_read_done,
  output logic display_id_load_default,
  // status indicator
  output logic display_id_status_indicator,
  // decoded configuration
  output pusd_pkg::pusd_cfg_t cfg,
  output logic network_setup_service_mode,
  output logic flash_upgrade_enable,
  output logic params_load_default,
  output pusd_pkg::pusd_route_t route_default,
  output logic route_default_load
);
  import pusd_pkg::*;

  // ----------------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------------
  // the phase counter is five bits wide, so sixteen on/off pairs fit; the check allows at most fifteen
  initial begin
    if (DEBOUNCE_CYCLES < 1 || BLINK_HALF_CYCLES < 1 || BLINKS < 1 || BLINKS > 15)
      $error("pusd_setup: bad parameters");
  end

  // the decoders are written for a 4-bit id field and a 3-bit baud field that tile the bank
  initial begin
    if (ID_W != 4 || BAUD_W != 3)
      $error("pusd_setup: switch field widths not served");
    if (ID_W + BAUD_W != SW_W || BAUD_LSB != ID_LSB + ID_W)
      $error("pusd_setup: switch fields do not tile the bank");
    if ($bits(ROUTE_ALL) != OUT_N || REPLY_DEFAULT == 4'h0 || int'(REPLY_DEFAULT) > OUT_N)
      $error("pusd_setup: bad route defaults");
  end

  // ----------------------------------------------------------------------
  // input conditioning
  // ----------------------------------------------------------------------
  // buttons share the switch filter: one window long enough for contact bounce, short enough for a press
  localparam int NIN = SW_W + 2;
  logic [NIN-1:0] clean;
  pusd_debounce #(.WIDTH(NIN), .STABLE_CYC(DEBOUNCE_CYCLES)) u_deb (
    .core_clk(core_clk),
    .rst(rst),
    .raw({factory_reset_button, display_id_capture_button, setup_switch}),
    .clean(clean)
  ); // [R12]

  wire [SW_W-1:0] sw_clean = clean[SW_W-1:0];
  wire cap_clean = clean[SW_W];
  wire frst_clean = clean[SW_W+1];

  function automatic pusd_baud_t baud_decode(input logic [2:0] code);
    case (code)
      3'h0: baud_decode = PUSD_BAUD_1200;
      3'h1: baud_decode = PUSD_BAUD_2400;
      3'h2: baud_decode = PUSD_BAUD_4800;
      3'h3: baud_decode = PUSD_BAUD_9600;
      3'h4: baud_decode = PUSD_BAUD_19200;
      default: baud_decode = PUSD_BAUD_9600; // [R12]
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // power-up sampling
  // ----------------------------------------------------------------------
  // wait a full debounce window plus margin so the filtered levels reflect the pins
  // three synchroniser stages sit in front of the debounce counter
  localparam int SYNC_STAGES = 3;
  localparam int WAIT_CYC = DEBOUNCE_CYCLES + SYNC_STAGES + SETTLE_CYC;
  localparam int WW = $clog2(WAIT_CYC + 1);
  logic [WW-1:0] wait_cnt;
  wire wait_done = (wait_cnt == WW'(WAIT_CYC));
  wire [3:0] id_code = sw_clean[ID_LSB +: ID_W];
  wire [2:0] baud_code = sw_clean[BAUD_LSB +: BAUD_W];
  wire is_service = (id_code == ID_SERVICE_CODE); // [R4]
  logic sample_now;
  assign sample_now = wait_done && !cfg.valid;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wait_cnt <= '0;
    end else if (!wait_done) begin
      wait_cnt <= wait_cnt + 1'b1;
    end
  end

  // cfg is written only once per reset; later switch moves are ignored
  // service mode reports unit 0 so no remote master can address it as an operating unit
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cfg <= '0;
    end else if (sample_now) begin
      cfg.valid <= 1'b1; // [R1]
      cfg.unit_id <= is_service ? 4'h0 : id_code + ID_OFFSET; // [R2] [R3] [R4]
      cfg.service_mode <= is_service; // [R5] [R6]
      cfg.baud <= baud_decode(baud_code); // [R7]
      cfg.factory_reset <= frst_clean; // [R10]
    end
  end

  // setup and upgrade share one latch, so both end only at the next power cycle
  assign network_setup_service_mode = cfg.valid && cfg.service_mode; // [R5]
  assign flash_upgrade_enable = cfg.valid && cfg.service_mode; // [R6]

  // ----------------------------------------------------------------------
  // factory defaults
  // ----------------------------------------------------------------------
  // one-cycle load pulses, issued at the sampling edge
  // the route value is constant; only the load pulse depends on the button
  always_ff @(posedge core_clk) begin
    if (rst) begin
      params_load_default <= 1'b0;
      display_id_load_default <= 1'b0;
      route_default_load <= 1'b0;
      route_default <= '0;
    end else begin
      params_load_default <= sample_now && frst_clean; // [R10]
      display_id_load_default <= sample_now && frst_clean; // [R10]
      route_default_load <= sample_now && frst_clean; // [R11]
      route_default <= '{route_mask: ROUTE_ALL, reply_output: REPLY_DEFAULT}; // [R11]
    end
  end

  // ----------------------------------------------------------------------
  // capture and blink
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    PUSD_IDLE = 2'b00,
    PUSD_READ = 2'b01,
    PUSD_BLINK = 2'b10
  } pusd_state_t;

  localparam int BW = $clog2(BLINK_HALF_CYCLES + 1);
  pusd_state_t state, next_state;
  logic cap_prev;
  logic [BW-1:0] half_cnt;
  logic [4:0] phase;
  // a press counts once, on the filtered rising edge; holding the button does not repeat
  wire cap_press = cap_clean && !cap_prev;
  wire half_done = (half_cnt == BW'(BLINK_HALF_CYCLES - 1));
  wire blink_end = half_done && (phase == 5'(2 * BLINKS - 1));

  // presses during read or blink are dropped, not queued
  always_comb begin
    next_state = state;
    case (state)
      PUSD_IDLE: if (cap_press && cfg.valid) next_state = PUSD_READ; // [R9]
      PUSD_READ: if (display_id_read_done) next_state = PUSD_BLINK;
      PUSD_BLINK: if (blink_end) next_state = PUSD_IDLE;
      default: next_state = PUSD_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= PUSD_IDLE;
      cap_prev <= 1'b0;
    end else begin
      state <= next_state;
      cap_prev <= cap_clean;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || state != PUSD_BLINK) begin
      half_cnt <= '0;
      phase <= '0;
    end else if (half_done) begin
      half_cnt <= '0;
      phase <= phase + 1'b1;
    end else begin
      half_cnt <= half_cnt + 1'b1;
    end
  end

  // start is a one-cycle pulse on entry to the read state
  wire next_start = (state == PUSD_IDLE) && (next_state == PUSD_READ);
  always_ff @(posedge core_clk) begin
    if (rst) begin
      display_id_read_start <= 1'b0;
    end else begin
      display_id_read_start <= next_start; // [R9]
    end
  end

  // ----------------------------------------------------------------------
  // status indicator
  // ----------------------------------------------------------------------
  // the lamp follows the phase the counter moves to at this edge; reading the phase it
  // leaves would stretch the first lit period by one cycle
  wire phase_step = (state == PUSD_BLINK) && half_done;
  wire next_lit = (next_state == PUSD_BLINK) && !(phase[0] ^ phase_step);
  always_ff @(posedge core_clk) begin
    if (rst) begin
      display_id_status_indicator <= 1'b0;
    end else begin
      display_id_status_indicator <= next_lit; // [R9]
    end
  end
endmodule // pusd_setup

// ==== dv/pusd_setup_checker.sv ====
`timescale 1ns/1ps
module pusd_setup_checker
  import pusd_pkg::*;
(
  // watched ports
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [pusd_pkg::SW_W-1:0] setup_switch,
  input wire logic factory_reset_button,
  input wire logic display_id_read_start,
  input wire logic display_id_load_default,
  input wire logic display_id_status_indicator,
  input wire pusd_pkg::pusd_cfg_t cfg,
  input wire logic network_setup_service_mode,
  input wire logic flash_upgrade_enable,
  input wire logic params_load_default,
  input wire pusd_pkg::pusd_route_t route_default,
  input wire logic route_default_load
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  function automatic pusd_baud_t bx(input logic [2:0] c);
    return c == 3'h0 ? PUSD_BAUD_1200 : c == 3'h1 ? PUSD_BAUD_2400 : c == 3'h2 ? PUSD_BAUD_4800 :
      c == 3'h4 ? PUSD_BAUD_19200 : PUSD_BAUD_9600;
  endfunction
  property p_hold; cfg.valid && $past(cfg.valid) |-> $stable(cfg); endproperty
  a_hold: assert property (p_hold) else $error("cfg moved after sampling");
  property p_id; $rose(cfg.valid) && $past(setup_switch[3:0]) != 4'hf |-> cfg.unit_id == $past(setup_switch[3:0]) + 4'h1;
  endproperty
  a_id: assert property (p_id) else $error("unit id wrong");
  property p_svc; $rose(cfg.valid) |-> cfg.service_mode == ($past(setup_switch[3:0]) == 4'hf); endproperty
  a_svc: assert property (p_svc) else $error("service mode wrong");
  property p_mode; flash_upgrade_enable == network_setup_service_mode && network_setup_service_mode == (cfg.valid && cfg.service_mode);
  endproperty
  a_mode: assert property (p_mode) else $error("service outputs wrong");
  property p_baud; $rose(cfg.valid) |-> cfg.baud == bx($past(setup_switch[6:4])); endproperty
  a_baud: assert property (p_baud) else $error("baud wrong");
  property p_fr; $rose(cfg.valid) |-> params_load_default == $past(factory_reset_button) ##1 !params_load_default; endproperty
  a_fr: assert property (p_fr) else $error("default load pulse wrong");
  property p_dflt; params_load_default == display_id_load_default; endproperty
  a_dflt: assert property (p_dflt) else $error("display default mismatch");
  property p_route; route_default_load |-> route_default == {ROUTE_ALL, REPLY_DEFAULT}; endproperty
  a_route: assert property (p_route) else $error("route default wrong");
  property p_start; display_id_read_start |-> cfg.valid ##1 !display_id_read_start; endproperty
  a_start: assert property (p_start) else $error("read start wrong");
  property p_blink; $rose(display_id_status_indicator) |-> display_id_status_indicator [*8] ##1 !display_id_status_indicator;
  endproperty
  a_blink: assert property (p_blink) else $error("blink length wrong");
  c_svc: cover property ($rose(cfg.valid) && cfg.service_mode);
  c_route: cover property (route_default_load);
  c_blink: cover property ($rose(display_id_status_indicator));
endmodule // pusd_setup_checker

// ==== dv/pusd_display_model.sv ====
`timescale 1ns/1ps
module pusd_display_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] lat,
  input wire logic read_start,
  output logic read_done
);
  logic [7:0] cnt;
  // identity read answers after a chosen latency
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt <= 8'h00;
      read_done <= 1'b0;
    end else begin
      read_done <= cnt == 8'h01;
      if (read_start) begin
        cnt <= lat;
      end else if (cnt != 8'h00) begin
        cnt <= cnt - 8'h01;
      end
    end
  end
endmodule // pusd_display_model

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
`define CHK(nm, got, exp) begin n_compared++; if ((got) !== (exp)) begin n_errors++; \
  $display("[ERR] %s exp %0h got %0h", nm, exp, got); end end
module tb_top;
  import pusd_pkg::*;
  typedef struct packed {logic [6:0] sw; logic [3:0] id; logic svc; pusd_baud_t baud;} pusd_row_t;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [6:0] setup_switch = 7'h00;
  logic cap = 1'b0;
  logic factory_reset_button = 1'b0;
  logic [7:0] lat = 8'h01;
  logic rd_start, rd_done, ind, ind_q, svc_o, fl_o, prm, dld, rld;
  pusd_cfg_t cfg;
  pusd_route_t rte;
  int n_errors = 0, n_compared = 0, n_start = 0, n_blink = 0;
  pusd_row_t rows[8] = '{'{7'h00, 4'h1, 1'b0, PUSD_BAUD_1200}, '{7'h11, 4'h2, 1'b0, PUSD_BAUD_2400},
    '{7'h2e, 4'hf, 1'b0, PUSD_BAUD_4800}, '{7'h37, 4'h8, 1'b0, PUSD_BAUD_9600},
    '{7'h45, 4'h6, 1'b0, PUSD_BAUD_19200}, '{7'h5f, 4'h0, 1'b1, PUSD_BAUD_9600},
    '{7'h63, 4'h4, 1'b0, PUSD_BAUD_9600}, '{7'h7a, 4'hb, 1'b0, PUSD_BAUD_9600}};
  always #2.5 core_clk = ~core_clk;
  pusd_setup #(.DEBOUNCE_CYCLES(4), .BLINK_HALF_CYCLES(8), .BLINKS(4)) i_dut (.core_clk(core_clk), .rst(rst),
    .setup_switch(setup_switch), .display_id_capture_button(cap), .factory_reset_button(factory_reset_button),
    .display_id_read_start(rd_start), .display_id_read_done(rd_done), .display_id_load_default(dld),
    .display_id_status_indicator(ind), .cfg(cfg), .network_setup_service_mode(svc_o),
    .flash_upgrade_enable(fl_o), .params_load_default(prm), .route_default(rte), .route_default_load(rld));
  pusd_display_model i_disp (.core_clk(core_clk), .rst(rst), .lat(lat), .read_start(rd_start), .read_done(rd_done));
  always @(posedge core_clk) begin
    ind_q <= ind;
    n_start <= n_start + (rd_start === 1'b1);
    n_blink <= n_blink + (ind === 1'b1 && ind_q === 1'b0);
  end
  task automatic powerup(input logic [6:0] sw, input logic fr);
    @(posedge core_clk);
    #1 setup_switch = sw;
    factory_reset_button = fr;
    rst = 1'b1;
    repeat (12) @(posedge core_clk);
    `CHK("rst_valid", cfg.valid, 1'b0)
    #1 rst = 1'b0;
    for (int i = 0; i < 200 && cfg.valid !== 1'b1; i++) begin
      @(posedge core_clk);
      #1;
    end
  endtask
  task results();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #300000;
    n_errors++;
    results();
  end
  initial begin
    foreach (rows[k]) begin
      powerup(rows[k].sw, 1'b0);
      `CHK("valid", cfg.valid, 1'b1)
      `CHK("frst_flag", cfg.factory_reset, 1'b0)
      `CHK("unit_id", cfg.unit_id, rows[k].id)
      `CHK("service", cfg.service_mode, rows[k].svc)
      `CHK("net_setup", svc_o, rows[k].svc)
      `CHK("flash", fl_o, rows[k].svc)
      `CHK("baud", cfg.baud, rows[k].baud)
      `CHK("params_dflt", prm, 1'b0)
      setup_switch = ~rows[k].sw;
      repeat (40) @(posedge core_clk);
      `CHK("id_held", cfg.unit_id, rows[k].id)
    end
    powerup(7'h00, 1'b1);
    `CHK("params_dflt", prm, 1'b1)
    `CHK("frst_flag", cfg.factory_reset, 1'b1)
    `CHK("disp_dflt", dld, 1'b1)
    `CHK("route_load", rld, 1'b1)
    `CHK("route_mask", rte.route_mask, 10'h3ff)
    `CHK("reply_out", rte.reply_output, 4'h1)
    factory_reset_button = 1'b0;
    foreach (rows[k]) if (k < 2) begin
      @(posedge core_clk);
      #1 lat = k == 0 ? 8'h01 : 8'h1e;
      cap = 1'b1;
      for (int i = 0; i < 100 && ind !== 1'b1; i++) @(posedge core_clk);
      #1 cap = 1'b0;
      repeat (10) @(posedge core_clk);
      #1 cap = 1'b1;
      repeat (12) @(posedge core_clk);
      #1 cap = 1'b0;
      repeat (80) @(posedge core_clk);
      `CHK("starts", n_start, k + 1)
      `CHK("blinks", n_blink, 4 * (k + 1))
    end
    results();
  end
endmodule // tb_top
bind pusd_setup pusd_setup_checker i_chk (.core_clk(core_clk), .rst(rst), .setup_switch(setup_switch),
  .factory_reset_button(factory_reset_button), .display_id_read_start(display_id_read_start),
  .display_id_load_default(display_id_load_default), .display_id_status_indicator(display_id_status_indicator),
  .cfg(cfg), .network_setup_service_mode(network_setup_service_mode), .flash_upgrade_enable(flash_upgrade_enable),
  .params_load_default(params_load_default), .route_default(route_default), .route_default_load(route_default_load));
